// ==== rtl/dsc_deep_sleep.sv ====
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// - select 010 plus sleep enters power-down
// - power-down stops oscillator, async wakers stay
// - power-down wakes on resets, usi, int0level, pinchange
// - power-down halts every generated clock
// - power-down wake waits fuse start-up delay
// - select 011 enters power-save, timer2/lcd run
// - timer2 wakes only if masked and global enabled
// - async oscillator stops unless lcd/timer2 use it
// - main clock stops unless lcd/timer2 use it
// - select 110 with crystal enters standby, six cycles
// - reduction bit stops peripheral clock, blocks access
// - clearing reduction bit restarts clock, state kept
// - reduction gating matters in active and idle
// - enabled converter stays on; relight forces extended
// - comparator off in deep sleep; reference kept only for bod, converter or comp_en with ac_ref
// - reference on when bod, comparator or converter
// - fuse-enabled brownout stays on in sleep
// - enabled watchdog runs in all sleep modes
// - input buffers off when io and adc stop
// - debug fuse keeps main clock in deep sleep, here only while jtag_en is set
// - jtd bit or unprogrammed fuse disables jtag
// - sleep only when sleep_arm set at instruction
// - interrupt wake halts core four extra cycles
module dsc_deep_sleep #(
  parameter logic [15:0] STARTUP_CYC = dsc_pkg::STARTUP_DEFAULT
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              sleep_exec,
  input  wire dsc_pkg::dsc_wake_s wake_in,
  input  wire logic              reset_wake,
  input  wire logic [1:0]        timer_two_irq_mask,
  input  wire logic              global_irq_en,
  input  wire logic              onchip_debug_fuse,
  input  wire logic              jtag_enable_fuse,
  input  wire logic              brownout_level_fuses,
  input  wire logic              watchdog_en,
  input  wire logic              adc_en,
  input  wire logic              comp_en,
  input  wire logic              tap_shifting,
  input  wire logic              tdo_data,
  output dsc_pkg::dsc_gate_s     gate,
  output logic [dsc_pkg::NUM_PERIPH-1:0] periph_clk_en,
  output logic                   core_run,
  output logic                   irq_service,
  output logic                   adc_extended,
  output logic                   brownout_en,
  output logic                   watchdog_run,
  output logic                   jtag_en,
  output logic                   tdo_out,
  output logic                   tdo_oe_n
);

  // pin inputs from the far side pass two flops
  logic [6:0] wake_s1;
  logic [6:0] wake_s2;
  logic       rst_s1;
  logic       rst_s2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_s1 <= 7'h00;
      wake_s2 <= 7'h00;
      rst_s1  <= 1'b0;
      rst_s2  <= 1'b0;
    end else begin
      wake_s1 <= wake_in;
      wake_s2 <= wake_s1;
      rst_s1  <= reset_wake;
      rst_s2  <= rst_s1;
    end
  end
  dsc_pkg::dsc_wake_s wk;
  assign wk = dsc_pkg::dsc_wake_s'(wake_s2);

  // registers
  logic [3:0]  sleep_ctrl;
  logic [4:0]  power_reduction_reg;
  logic        jtag_disable_bit;
  logic [15:0] cfg;
  dsc_pkg::dsc_state_e state;
  logic [2:0]  mode;
  logic [15:0] cnt;
  logic        adc_en_q;
  logic        by_irq;

  // ahb address phase capture
  logic       ph_wr;
  logic       ph_rd;
  logic [7:0] ph_addr;
  wire        a_take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_wr   <= a_take & hwrite;
      ph_rd   <= a_take & ~hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  wire sel_sc = ph_addr == dsc_pkg::OFS_SLEEP_CTRL;
  wire sel_pr = ph_addr == dsc_pkg::OFS_PWR_RED;
  wire sel_mc = ph_addr == dsc_pkg::OFS_MCU_CTRL;
  wire sel_cf = ph_addr == dsc_pkg::OFS_CONFIG;
  wire sel_st = ph_addr == dsc_pkg::OFS_STATUS;

  // register writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_ctrl          <= dsc_pkg::RST_SLEEP_CTRL;
      power_reduction_reg <= dsc_pkg::RST_PWR_RED;
      jtag_disable_bit    <= 1'b0;
      cfg                 <= dsc_pkg::RST_CONFIG;
    end else if (ph_wr) begin
      if (sel_sc) sleep_ctrl <= hwdata[3:0];
      if (sel_pr) power_reduction_reg <= hwdata[4:0];
      if (sel_mc) jtag_disable_bit <= hwdata[dsc_pkg::MC_JTD_BIT];
      if (sel_cf) cfg <= hwdata[15:0];
    end
  end

  // read mux; unmapped reads return zero
  logic [31:0] rd_mux;
  assign rd_mux = sel_sc ? {28'h000_0000, sleep_ctrl} :
                  sel_pr ? {27'h000_0000, power_reduction_reg} :
                  sel_mc ? {24'h00_0000, jtag_disable_bit, 7'h00} :
                  sel_cf ? {16'h0000, cfg} :
                  sel_st ? {24'h00_0000, mode, state} : 32'h0000_0000;
  // reads take one wait state so the data already stands when the master samples it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
    end else if (ph_rd) begin
      hrdata    <= rd_mux;
      hreadyout <= 1'b1;
    end else if (a_take & ~hwrite) begin
      hreadyout <= 1'b0;
    end
  end
  // writes need no wait; the response is always okay
  assign hresp = 1'b0;

  wire [2:0] sel      = sleep_ctrl[3:1];
  wire       arm      = sleep_ctrl[dsc_pkg::SC_ARM_BIT];
  wire       xtal     = cfg[dsc_pkg::CF_XTAL_BIT];
  wire       t2_asy   = cfg[dsc_pkg::CF_T2ASY_BIT];
  wire       lc_asy   = cfg[dsc_pkg::CF_LCASY_BIT];
  wire       t2_on    = cfg[dsc_pkg::CF_T2EN_BIT];
  wire       lc_on    = cfg[dsc_pkg::CF_LCEN_BIT];
  wire       ac_ref   = cfg[dsc_pkg::CF_ACREF_BIT];

  // legal entry; reserved codes and standby without crystal are ignored
  wire valid_sel = sel == dsc_pkg::SEL_IDLE | sel == dsc_pkg::SEL_ADCNR |
                   sel == dsc_pkg::SEL_PDOWN | sel == dsc_pkg::SEL_PSAVE |
                   (sel == dsc_pkg::SEL_STANDBY & xtal);
  wire enter = sleep_exec & arm & valid_sel;

  // wake qualification per mode
  wire t2_wake = (wk.timer2_ovf & timer_two_irq_mask[0] |
                  wk.timer2_cmp & timer_two_irq_mask[1]) & global_irq_en;
  wire deep_irq = wk.usi_start | wk.ext_irq_zero_level | wk.pin_change;
  wire irq_wake = (mode == dsc_pkg::SEL_PSAVE) ? deep_irq | t2_wake | wk.lcd_irq :
                  (mode == dsc_pkg::SEL_IDLE | mode == dsc_pkg::SEL_ADCNR) ?
                  deep_irq | wk.other_irq | wk.lcd_irq | t2_wake : deep_irq;
  wire wake_ev = irq_wake | rst_s2;

  // start-up delay: fuse length, standby six cycles, idle one cycle
  wire [15:0] start_len = (mode == dsc_pkg::SEL_STANDBY) ? dsc_pkg::STANDBY_CYC :
                          (mode == dsc_pkg::SEL_IDLE) ? 16'h0001 : STARTUP_CYC;

  dsc_pkg::dsc_state_e next_state;
  logic [15:0] next_cnt;
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      dsc_pkg::ST_ACTIVE: begin
        if (enter) next_state = dsc_pkg::ST_SLEEP;
      end
      dsc_pkg::ST_SLEEP: begin
        if (wake_ev) begin
          next_state = dsc_pkg::ST_WAKE;
          next_cnt   = start_len;
        end
      end
      dsc_pkg::ST_WAKE: begin
        next_cnt = cnt - 16'h0001;
        if (cnt == 16'h0001) begin
          next_state = by_irq ? dsc_pkg::ST_HALT : dsc_pkg::ST_RESUME;
          next_cnt   = dsc_pkg::IRQ_HALT_CYC;
        end
      end
      dsc_pkg::ST_HALT: begin
        next_cnt = cnt - 16'h0001;
        if (cnt == 16'h0001) next_state = dsc_pkg::ST_RESUME;
      end
      dsc_pkg::ST_RESUME: next_state = dsc_pkg::ST_ACTIVE;
      default: next_state = dsc_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state  <= dsc_pkg::ST_ACTIVE;
      cnt    <= 16'h0000;
      mode   <= dsc_pkg::SEL_IDLE;
      by_irq <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      if (state == dsc_pkg::ST_ACTIVE && enter) mode <= sel;
      if (state == dsc_pkg::ST_SLEEP && wake_ev) by_irq <= ~rst_s2;
    end
  end

  // clock gating per mode
  wire slp     = state == dsc_pkg::ST_SLEEP;
  wire deep    = slp & (mode == dsc_pkg::SEL_PDOWN | mode == dsc_pkg::SEL_PSAVE |
                        mode == dsc_pkg::SEL_STANDBY);
  wire psave   = slp & mode == dsc_pkg::SEL_PSAVE;
  wire adcnr   = slp & mode == dsc_pkg::SEL_ADCNR;
  wire use_asy = (t2_on & t2_asy) | (lc_on & lc_asy);
  wire use_syn = (t2_on & ~t2_asy) | (lc_on & ~lc_asy);
  wire dbg_hold = onchip_debug_fuse & jtag_en & slp &
                  (mode == dsc_pkg::SEL_PDOWN | mode == dsc_pkg::SEL_PSAVE);
  dsc_pkg::dsc_gate_s next_gate;
  always_comb begin
    next_gate.cpu       = ~slp;
    next_gate.io        = ~deep & ~adcnr;
    next_gate.adc       = ~deep;
    next_gate.asy       = ~deep | (psave & use_asy);
    next_gate.main_osc  = ~deep | (psave & use_syn) | dbg_hold |
                          (slp & mode == dsc_pkg::SEL_STANDBY);
    next_gate.timer_osc = ~deep | (psave & use_asy);
    next_gate.in_buf    = next_gate.io | next_gate.adc;
    next_gate.comp      = comp_en & ~deep;
    next_gate.vref      = brownout_level_fuses | adc_en |
                          (comp_en & (~deep | ac_ref));
  end

  // outputs registered
  wire [4:0] next_pclk = ~power_reduction_reg & {5{next_gate.io}};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate          <= '1;
      periph_clk_en <= 5'h1F;
      core_run      <= 1'b1;
      irq_service   <= 1'b0;
      adc_extended  <= 1'b0;
      brownout_en   <= 1'b0;
      watchdog_run  <= 1'b0;
      jtag_en       <= 1'b0;
      tdo_out       <= 1'b0;
      tdo_oe_n      <= 1'b1;
      adc_en_q      <= 1'b0;
    end else begin
      gate          <= next_gate;
      periph_clk_en <= next_pclk;
      core_run      <= next_state == dsc_pkg::ST_ACTIVE;
      irq_service   <= state == dsc_pkg::ST_HALT && cnt == 16'h0001;
      adc_en_q      <= adc_en;
      if (adc_en & ~adc_en_q) adc_extended <= 1'b1;
      else if (~adc_en) adc_extended <= 1'b0;
      brownout_en   <= brownout_level_fuses;
      watchdog_run  <= watchdog_en;
      jtag_en       <= jtag_enable_fuse & ~jtag_disable_bit;
      tdo_out       <= tdo_data;
      tdo_oe_n      <= ~(jtag_en & tap_shifting);
    end
  end

  // a level wake must hold until sleep leaves; relies on the far side
  a_enter_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
    state == dsc_pkg::ST_ACTIVE && sleep_exec && !arm |=> state != dsc_pkg::ST_SLEEP)
    else $error("sleep entered without arm");
  a_pdown_osc_off: assert property (@(posedge hclk) disable iff (!hresetn)
    slp && mode == dsc_pkg::SEL_PDOWN && !onchip_debug_fuse |=> !gate.main_osc)
    else $error("oscillator running in power-down");
  a_pdown_clk_off: assert property (@(posedge hclk) disable iff (!hresetn)
    slp && mode == dsc_pkg::SEL_PDOWN |=> !gate.io && !gate.adc && !gate.cpu)
    else $error("clock running in power-down");
  // wake and halt are multi-step, so their shapes are named once
  sequence s_wake_six;
    state == dsc_pkg::ST_WAKE [*6] ##1 state != dsc_pkg::ST_WAKE;
  endsequence
  sequence s_halt_four;
    state == dsc_pkg::ST_HALT [*4] ##1 state == dsc_pkg::ST_RESUME;
  endsequence
  a_standby_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    state == dsc_pkg::ST_SLEEP && mode == dsc_pkg::SEL_STANDBY && wake_ev |=> s_wake_six)
    else $error("standby wake not six cycles");
  a_halt_four: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(state == dsc_pkg::ST_HALT) |-> s_halt_four)
    else $error("halt not four cycles");
  a_t2_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    slp && mode == dsc_pkg::SEL_PSAVE && !global_irq_en && !deep_irq
    && !wk.lcd_irq && !rst_s2 |=> state == dsc_pkg::ST_SLEEP)
    else $error("timer two woke without enable");
  a_prr_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    power_reduction_reg[0] |=> !periph_clk_en[0])
    else $error("reduced peripheral still clocked");
  a_inbuf_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !gate.io && !gate.adc |-> !gate.in_buf)
    else $error("input buffers on with clocks off");
  a_jtag_dis: assert property (@(posedge hclk) disable iff (!hresetn)
    jtag_disable_bit |=> !jtag_en)
    else $error("jtag enabled despite disable bit");

  // entry, gating and keep-alive checks on the registered enables
  a_pdown_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    state == dsc_pkg::ST_ACTIVE && sleep_exec && arm && sel == dsc_pkg::SEL_PDOWN
    |=> state == dsc_pkg::ST_SLEEP && mode == dsc_pkg::SEL_PDOWN)
    else $error("power-down not entered");
  a_psave_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    state == dsc_pkg::ST_ACTIVE && sleep_exec && arm && sel == dsc_pkg::SEL_PSAVE
    |=> state == dsc_pkg::ST_SLEEP && mode == dsc_pkg::SEL_PSAVE)
    else $error("power-save not entered");
  a_standby_osc: assert property (@(posedge hclk) disable iff (!hresetn)
    slp && mode == dsc_pkg::SEL_STANDBY |=> gate.main_osc)
    else $error("oscillator stopped in standby");
  a_psave_tosc: assert property (@(posedge hclk) disable iff (!hresetn)
    psave |=> gate.timer_osc == $past(use_asy) && gate.asy == $past(use_asy))
    else $error("timer oscillator wrong in power-save");
  a_psave_main: assert property (@(posedge hclk) disable iff (!hresetn)
    psave && !onchip_debug_fuse |=> gate.main_osc == $past(use_syn))
    else $error("main clock wrong in power-save");
  a_pdown_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    slp && mode == dsc_pkg::SEL_PDOWN && !rst_s2 && !deep_irq |=> state == dsc_pkg::ST_SLEEP)
    else $error("power-down left without a listed waker");
  a_comp_off: assert property (@(posedge hclk) disable iff (!hresetn)
    deep |=> !gate.comp)
    else $error("comparator on in deep sleep");
  a_vref_need: assert property (@(posedge hclk) disable iff (!hresetn)
    brownout_level_fuses || adc_en |=> gate.vref)
    else $error("reference off while needed");
  a_vref_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !brownout_level_fuses && !adc_en && !comp_en |=> !gate.vref)
    else $error("reference on with no user");
  a_bod_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    brownout_level_fuses |=> brownout_en)
    else $error("brownout detector dropped");
  a_wdt_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    watchdog_en |=> watchdog_run)
    else $error("watchdog stopped");
  a_dbg_clock: assert property (@(posedge hclk) disable iff (!hresetn)
    slp && (mode == dsc_pkg::SEL_PDOWN || mode == dsc_pkg::SEL_PSAVE) && onchip_debug_fuse
    && jtag_en |=> gate.main_osc)
    else $error("main clock stopped with debug on");
  a_tdo_float: assert property (@(posedge hclk) disable iff (!hresetn)
    jtag_en && !tap_shifting |=> tdo_oe_n)
    else $error("tdo driven while not shifting");
  a_prr_restore: assert property (@(posedge hclk) disable iff (!hresetn)
    state == dsc_pkg::ST_ACTIVE && !power_reduction_reg[0] |=> periph_clk_en[0])
    else $error("peripheral clock not restored");
  a_deep_pclk: assert property (@(posedge hclk) disable iff (!hresetn)
    deep |=> periph_clk_en == 5'h00)
    else $error("peripheral clock running in deep sleep");
  a_adc_relight: assert property (@(posedge hclk) disable iff (!hresetn)
    adc_en && !adc_en_q |=> adc_extended)
    else $error("extended conversion not flagged");
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    ph_rd |-> !hreadyout)
    else $error("read data phase without wait state");

endmodule

// ==== rtl/dsc_pkg.sv ====
package dsc_pkg;

  // sleep-mode select encodings
  localparam logic [2:0] SEL_IDLE    = 3'h0;
  localparam logic [2:0] SEL_ADCNR   = 3'h1;
  localparam logic [2:0] SEL_PDOWN   = 3'h2;
  localparam logic [2:0] SEL_PSAVE   = 3'h3;
  localparam logic [2:0] SEL_STANDBY = 3'h6;

  // register byte offsets
  localparam logic [7:0] OFS_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] OFS_PWR_RED    = 8'h04;
  localparam logic [7:0] OFS_MCU_CTRL   = 8'h08;
  localparam logic [7:0] OFS_CONFIG     = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;

  // field positions
  localparam int SC_ARM_BIT   = 0;
  localparam int SC_SEL_LSB   = 1;
  localparam int MC_JTD_BIT   = 7;
  localparam int CF_XTAL_BIT  = 0;
  localparam int CF_T2ASY_BIT = 1;
  localparam int CF_LCASY_BIT = 2;
  localparam int CF_T2EN_BIT  = 3;
  localparam int CF_LCEN_BIT  = 4;
  localparam int CF_ACREF_BIT = 5;
  localparam int CF_SUT_LSB   = 8;

  // reset values
  localparam logic [3:0]  RST_SLEEP_CTRL = 4'h0;
  localparam logic [4:0]  RST_PWR_RED    = 5'h00;
  localparam logic [15:0] RST_CONFIG     = 16'h0000;

  // cycle counts
  localparam int          STANDBY_NS      = 300;   // six cycles at 50 ns
  localparam int          CLK_NS          = 50;
  localparam logic [15:0] STANDBY_CYC     = 16'(STANDBY_NS / CLK_NS);
  localparam logic [15:0] IRQ_HALT_CYC    = 16'h0004;
  localparam logic [15:0] STARTUP_DEFAULT = 16'h4000;
  localparam int          NUM_PERIPH      = 5;

  typedef enum logic [4:0] {
    ST_ACTIVE = 5'b00001,
    ST_SLEEP  = 5'b00010,
    ST_WAKE   = 5'b00100,
    ST_HALT   = 5'b01000,
    ST_RESUME = 5'b10000
  } dsc_state_e;

  // wake sources from the far side
  typedef struct packed {
    logic ext_irq_zero_level;
    logic pin_change;
    logic usi_start;
    logic lcd_irq;
    logic timer2_ovf;
    logic timer2_cmp;
    logic other_irq;
  } dsc_wake_s;

  // clock and analog enables
  typedef struct packed {
    logic cpu;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic timer_osc;
    logic in_buf;
    logic vref;
    logic comp;
  } dsc_gate_s;

endpackage

// ==== tb/deep_sleep_clock_gating_bench.sv ====
`timescale 1ns/10ps
module deep_sleep_clock_gating_bench;
  localparam logic [15:0] ST   = 16'h0008;
  localparam logic [31:0] A_SC = {24'h00_0000, dsc_pkg::OFS_SLEEP_CTRL};
  localparam logic [31:0] A_PR = {24'h00_0000, dsc_pkg::OFS_PWR_RED};
  localparam logic [31:0] A_MC = {24'h00_0000, dsc_pkg::OFS_MCU_CTRL};
  localparam logic [31:0] A_CF = {24'h00_0000, dsc_pkg::OFS_CONFIG};
  localparam logic [31:0] A_ST = {24'h00_0000, dsc_pkg::OFS_STATUS};
  logic               hclk, hresetn, hsel, hwrite, hready, sleep_exec, reset_wake;
  logic               global_irq_en, onchip_debug_fuse, jtag_enable_fuse;
  logic               brownout_level_fuses, watchdog_en, adc_en, comp_en;
  logic               tap_shifting, tdo_data, hresp, core_run, irq_service;
  logic               adc_extended, brownout_en, watchdog_run, jtag_en, tdo_out, tdo_oe_n;
  logic [31:0]        haddr, hwdata, hrdata, r;
  logic [1:0]         htrans, timer_two_irq_mask;
  logic [2:0]         hsize;
  logic [4:0]         periph_clk_en, v;
  dsc_pkg::dsc_wake_s req, wake_in;
  dsc_pkg::dsc_gate_s gate;
  int                 bad_count, checks_done, irqs, seed, n, base, q[$];

  dsc_deep_sleep #(.STARTUP_CYC(ST)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .sleep_exec(sleep_exec), .wake_in(wake_in), .reset_wake(reset_wake),
    .timer_two_irq_mask(timer_two_irq_mask), .global_irq_en(global_irq_en),
    .onchip_debug_fuse(onchip_debug_fuse), .jtag_enable_fuse(jtag_enable_fuse),
    .brownout_level_fuses(brownout_level_fuses), .watchdog_en(watchdog_en),
    .adc_en(adc_en), .comp_en(comp_en), .tap_shifting(tap_shifting), .tdo_data(tdo_data),
    .gate(gate), .periph_clk_en(periph_clk_en), .core_run(core_run),
    .irq_service(irq_service), .adc_extended(adc_extended), .brownout_en(brownout_en),
    .watchdog_run(watchdog_run), .jtag_en(jtag_en), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n));

  dsc_far_model far_u (.hclk(hclk), .hresetn(hresetn), .core_run(core_run), .req(req),
    .wake_in(wake_in));

  // clock, 50 ns period
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // count serviced interrupts
  always @(posedge hclk) if (irq_service === 1'b1) irqs++;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic hung();
    bad_count++;
    complete_run();
  endtask

  // one single transfer; hold each phase until hready is seen high
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    htrans <= 2'b10;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 100) hung();
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic wait_run(input logic l, output int c);
    c = 0;
    while (core_run !== l && c < 300) begin @(posedge hclk); c++; end
    if (c >= 300) hung();
  endtask

  // arm, select, issue the sleep instruction, wait for the core to stop
  task automatic nap(input logic [2:0] sel, input logic [15:0] cfg);
    int c;
    wr(A_CF, {16'h0000, cfg});
    wr(A_SC, {28'h000_0000, sel, 1'b1});
    @(posedge hclk) sleep_exec <= 1'b1;
    @(posedge hclk) sleep_exec <= 1'b0;
    wait_run(1'b0, c);
    repeat (2) @(posedge hclk);
  endtask

  task automatic poke(input dsc_pkg::dsc_wake_s s);
    @(posedge hclk) req <= s;
    @(posedge hclk) req <= '0;
  endtask

  // model: latency = base overhead + start-up length + four halt cycles if interrupt
  initial begin
    {hsel, hwrite, sleep_exec, reset_wake, global_irq_en, onchip_debug_fuse} = '0;
    {tap_shifting, tdo_data, adc_en, comp_en} = '0;
    {haddr, hwdata, htrans, hsize, timer_two_irq_mask, req} = '0;
    {jtag_enable_fuse, brownout_level_fuses, watchdog_en} = 3'b111;
    seed = 63688;
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, A_SC, 0, r);
    chk("sleep_ctrl", 0, r);
    chk("hresp", 0, hresp);
    chk("prr_clk", 32'h1f, periph_clk_en);
    for (int i = 0; i < 3; i++) begin
      v = 5'($random(seed));
      wr(A_PR, {27'h0, v});
      repeat (2) @(posedge hclk);
      chk("prr_clk", {27'h0, ~v}, periph_clk_en);
      bus(1'b0, A_PR, 0, r);
      chk("prr_rd", {27'h0, v}, r);
    end
    wr(A_PR, 0);
    repeat (2) @(posedge hclk);
    chk("prr_clr", 32'h1f, periph_clk_en);
    bus(1'b0, 32'h0000_0040, 0, r);
    chk("unmapped", 0, r);
    wr(A_SC, {28'h0, dsc_pkg::SEL_PDOWN, 1'b0});
    @(posedge hclk) sleep_exec <= 1'b1;
    @(posedge hclk) sleep_exec <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("no_arm", 1, core_run);
    wr(A_SC, {28'h0, 3'h4, 1'b1});
    @(posedge hclk) sleep_exec <= 1'b1;
    @(posedge hclk) sleep_exec <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("reserved", 1, core_run);
    comp_en <= 1'b1;
    for (int i = 4; i < 7; i++) begin
      nap(dsc_pkg::SEL_PDOWN, 16'h0000);
      chk("pd_clks", 0, {gate.cpu, gate.io, gate.adc, gate.main_osc});
      chk("pd_keep", 3'b111, {brownout_en, watchdog_run, gate.vref});
      chk("pd_comp", 0, gate.comp);
      chk("pd_inbuf", 0, gate.in_buf);
      bus(1'b0, A_ST, 0, r);
      chk("pd_state", {dsc_pkg::SEL_PDOWN, dsc_pkg::ST_SLEEP}, r[7:0]);
      poke(7'h01);
      repeat (30) @(posedge hclk);
      chk("pd_other", 0, core_run);
      poke(7'(1 << i));
      wait_run(1'b1, n);
      q.push_back(n);
    end
    base = 5; // two sync flops, wake edge, resume edge, edge that samples core_run
    chk("pd_lat", 1, q[0] >= ST + 4);
    foreach (q[k]) chk("pd_lat", base + ST + 4, q[k]);
    chk("irqs", 3, irqs);
    nap(dsc_pkg::SEL_PDOWN, 16'h0000);
    reset_wake <= 1'b1;
    wait_run(1'b1, n);
    reset_wake <= 1'b0;
    chk("rst_lat", base + ST, n);
    nap(dsc_pkg::SEL_STANDBY, 16'h0001);
    chk("sb_osc", 1, gate.main_osc);
    poke(7'h40);
    wait_run(1'b1, n);
    chk("sb_lat", base + 6 + 4, n);
    nap(dsc_pkg::SEL_PSAVE, 16'h000a);
    chk("ps_osc", 3'b101, {gate.asy, gate.main_osc, gate.timer_osc});
    poke(7'h04);
    repeat (30) @(posedge hclk);
    chk("ps_unmasked", 0, core_run);
    timer_two_irq_mask <= 2'b01;
    global_irq_en <= 1'b1;
    wait_run(1'b1, n);
    // the wake level was already synchronised; only the mask and the global enable were missing
    chk("ps_lat", base + ST + 2, n);
    onchip_debug_fuse <= 1'b1;
    nap(dsc_pkg::SEL_PDOWN, 16'h0000);
    chk("dbg_osc", 1, gate.main_osc);
    poke(7'h20);
    wait_run(1'b1, n);
    onchip_debug_fuse <= 1'b0;
    chk("jtag_on", 2'b11, {jtag_en, tdo_oe_n});
    {tdo_data, tap_shifting} <= 2'b11;
    repeat (2) @(posedge hclk);
    chk("tdo_drive", 2'b10, {tdo_out, tdo_oe_n});
    {tdo_data, tap_shifting} <= 2'b00;
    wr(A_MC, 32'h0000_0080);
    repeat (2) @(posedge hclk);
    chk("jtag_jtd", 0, jtag_en);
    wr(A_MC, 0);
    jtag_enable_fuse <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("jtag_fuse", 0, jtag_en);
    {brownout_level_fuses, comp_en} <= 2'b00;
    repeat (3) @(posedge hclk);
    chk("vref_off", 2'b00, {gate.vref, brownout_en});
    adc_en <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("vref_adc", 2'b11, {gate.vref, adc_extended});
    // idle keeps io and converter clocks, so the reduction bit still gates
    wr(A_PR, 32'h0000_0001);
    nap(dsc_pkg::SEL_IDLE, 16'h0000);
    chk("idle_clks", 4'b0111, {gate.cpu, gate.io, gate.adc, gate.in_buf});
    chk("idle_pclk", 5'h1e, periph_clk_en);
    poke(7'h01);
    wait_run(1'b1, n);
    chk("idle_lat", base + 1 + 4, n);
    complete_run();
  end

  // no wait may hang the run
  initial begin
    #3_000_000;
    hung();
  end
endmodule

// ==== tb/dsc_far_model.sv ====
`timescale 1ns/10ps
// far side: wake sources are held until the core runs again
module dsc_far_model (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               core_run,
  input  wire dsc_pkg::dsc_wake_s req,
  output dsc_pkg::dsc_wake_s      wake_in
);
  // a short level could be lost in the two-flop synchroniser, so hold it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wake_in <= '0;
    else if (req != '0)
      wake_in <= wake_in | req;
    else if (core_run)
      wake_in <= '0;
  end
endmodule
